/* File: pkg/vicrb_regs.vh */
// Purpose: register map, field positions and reset values of the
//          vectored interrupt controller read-back section
// Assumes: 12-bit byte address, one aligned 32-bit word per register
// Notes:   definitions only
`ifndef VICRB_REGS_VH
`define VICRB_REGS_VH

`define VICRB_AW 12
`define VICRB_NSRC 32
`define VICRB_PRIO_BASE 12'h000
`define VICRB_SVR_BASE 12'h080
`define VICRB_NVR_OFF 12'h100
`define VICRB_FVR_OFF 12'h104
`define VICRB_CSS_OFF 12'h108
`define VICRB_PEND_OFF 12'h10C
`define VICRB_ENA_OFF 12'h110
`define VICRB_CLS_OFF 12'h114
`define VICRB_ENCMD_OFF 12'h120
`define VICRB_SPUR_OFF 12'h134
`define VICRB_EVST_OFF 12'h150
`define VICRB_EVMSK_OFF 12'h154
`define VICRB_VEC_RESET 32'h0000_0000
`define VICRB_PRIO_W 3
`define VICRB_FAST_SRC 5'h00
`define VICRB_CLS_FAST_BIT 0
`define VICRB_CLS_NORM_BIT 1
`define VICRB_EV_SPUR_BIT 0
`define VICRB_EV_NORM_BIT 1
`define VICRB_EV_FAST_BIT 2
`define VICRB_EV_W 3

`endif

/* File: design/vicrb_vector_mem.v */
// Purpose: 32-entry store of per-source handler vectors
// Assumes: one write port, one read port with registered read data
// Notes:   reset clears every entry so unprogrammed reads give zero
`include "vicrb_regs.vh"
`default_nettype none

module vicrb_vector_mem (
  // clock, reset, enable
  input wire ref_clk,
  input wire reset,
  input wire ce,
  // write port
  input wire wr_en,
  input wire [4:0] wr_idx,
  input wire [31:0] wr_data,
  // read port
  input wire [4:0] rd_idx,
  output reg [31:0] rd_q
);

  reg [31:0] vec_mem [0:`VICRB_NSRC-1];
  integer i;

  always @(posedge ref_clk) begin
    if (reset) begin
      for (i = 0; i < `VICRB_NSRC; i = i + 1) begin
        vec_mem[i] <= `VICRB_VEC_RESET;
      end
      rd_q <= `VICRB_VEC_RESET;
    end else if (ce) begin
      if (wr_en) begin
        vec_mem[wr_idx] <= wr_data;
      end
      rd_q <= vec_mem[rd_idx];
    end
  end

endmodule
`default_nettype wire

/* File: design/vicrb_top.v */
// Purpose: vector read-back, status, pending and enable registers of a
//          32-source vectored interrupt controller, driving the core's
//          active-low normal and fast request lines
// Assumes: sources are asynchronous high-level requests; plain register
//          port with read data one cycle after the read strobe
// Notes:   source 0 is the fast source and takes no priority
//
// The placing of the registers and strobed register access were decided locally.
`include "vicrb_regs.vh"
`default_nettype none

module vicrb_top (
  // clock, reset, enable
  input wire ref_clk,
  input wire reset,
  input wire ce,
  // register port
  input wire [11:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [31:0] reg_rdata,
  // interrupt sources
  input wire [31:0] src_req,
  // core request lines
  output reg core_normal_request_n,
  output reg core_fast_request_n,
  // event interrupt
  output wire irq
);

  // source request synchroniser
  reg [31:0] src_meta_reg;
  reg [31:0] pending_reg;

  // register state
  reg [31:0] enabled_reg;
  reg [31:0] spurious_vector_reg;
  reg [`VICRB_NSRC*`VICRB_PRIO_W-1:0] prio_reg;
  reg [4:0] current_source_number_reg;
  reg [`VICRB_EV_W-1:0] ev_status_reg;
  reg [`VICRB_EV_W-1:0] ev_mask_reg;

  // read path
  reg [31:0] rdata_reg;
  reg rvalid_reg;
  reg use_mem_reg;
  reg [4:0] mem_rd_idx;
  wire [31:0] mem_q;

  // selection
  reg [4:0] best_idx;
  reg [2:0] best_prio;
  reg best_found;
  reg [4:0] cand;
  integer k;

  wire [31:0] active = pending_reg & enabled_reg;
  wire fast_active = active[0];

  // address decode; windows compared on their upper five bits only
  localparam [11:0] SVR_BASE = `VICRB_SVR_BASE;
  localparam [11:0] PRIO_BASE = `VICRB_PRIO_BASE;
  wire in_svr = (reg_addr[11:7] == SVR_BASE[11:7]);
  wire in_prio = (reg_addr[11:7] == PRIO_BASE[11:7]);
  wire [4:0] word_idx = reg_addr[6:2];
  wire rd_nvr = reg_rd && (reg_addr == `VICRB_NVR_OFF);
  wire rd_fvr = reg_rd && (reg_addr == `VICRB_FVR_OFF);

  // highest level wins; on a tie the lower source number
  always @* begin
    best_idx = 5'h00;
    best_prio = 3'h0;
    best_found = 1'b0;
    cand = 5'h00;
    for (k = 1; k < `VICRB_NSRC; k = k + 1) begin
      cand = k[4:0];
      if (active[k] && (!best_found ||
          prio_reg[k*`VICRB_PRIO_W +: `VICRB_PRIO_W] > best_prio)) begin
        best_found = 1'b1;
        best_idx = cand;
        best_prio = prio_reg[k*`VICRB_PRIO_W +: `VICRB_PRIO_W];
      end
    end
  end

  // memory read index: vector reads pick the entry on the read cycle
  always @* begin
    mem_rd_idx = word_idx;
    if (rd_nvr) begin
      mem_rd_idx = best_idx;
    end else if (rd_fvr) begin
      mem_rd_idx = `VICRB_FAST_SRC;
    end
  end

  vicrb_vector_mem u_mem (
    .ref_clk(ref_clk),
    .reset(reset),
    .ce(ce),
    .wr_en(reg_wr && in_svr),
    .wr_idx(word_idx),
    .wr_data(reg_wdata),
    .rd_idx(mem_rd_idx),
    .rd_q(mem_q)
  );

  // two flops before any logic reads the source pins
  always @(posedge ref_clk) begin
    if (reset) begin
      src_meta_reg <= 32'h0000_0000;
      pending_reg <= 32'h0000_0000;
    end else if (ce) begin
      src_meta_reg <= src_req;
      pending_reg <= src_meta_reg;
    end
  end

  // core lines, active low
  always @(posedge ref_clk) begin
    if (reset) begin
      core_normal_request_n <= 1'b1;
      core_fast_request_n <= 1'b1;
    end else if (ce) begin
      core_normal_request_n <= ~best_found;
      core_fast_request_n <= ~fast_active;
    end
  end

  // writable state; read-only offsets fall through untouched
  always @(posedge ref_clk) begin
    if (reset) begin
      enabled_reg <= 32'h0000_0000;
      spurious_vector_reg <= `VICRB_VEC_RESET;
      prio_reg <= {(`VICRB_NSRC*`VICRB_PRIO_W){1'b0}};
      ev_mask_reg <= {`VICRB_EV_W{1'b0}};
    end else if (ce && reg_wr) begin
      if (reg_addr == `VICRB_ENCMD_OFF) begin
        enabled_reg <= enabled_reg | reg_wdata;
      end
      if (reg_addr == `VICRB_SPUR_OFF) begin
        spurious_vector_reg <= reg_wdata;
      end
      if (reg_addr == `VICRB_EVMSK_OFF) begin
        ev_mask_reg <= reg_wdata[`VICRB_EV_W-1:0];
      end
      if (in_prio) begin
        prio_reg[word_idx*`VICRB_PRIO_W +: `VICRB_PRIO_W] <=
          reg_wdata[`VICRB_PRIO_W-1:0];
      end
    end
  end

  // current source follows the normal vector read
  always @(posedge ref_clk) begin
    if (reset) begin
      current_source_number_reg <= 5'h00;
    end else if (ce && rd_nvr && best_found) begin
      current_source_number_reg <= best_idx;
    end
  end

  // events; a new event in the clearing cycle survives the clear
  wire [`VICRB_EV_W-1:0] ev_set;
  assign ev_set[`VICRB_EV_SPUR_BIT] = rd_nvr && !best_found;
  assign ev_set[`VICRB_EV_NORM_BIT] = best_found && core_normal_request_n;
  assign ev_set[`VICRB_EV_FAST_BIT] = fast_active && core_fast_request_n;

  always @(posedge ref_clk) begin
    if (reset) begin
      ev_status_reg <= {`VICRB_EV_W{1'b0}};
    end else if (ce) begin
      if (reg_wr && reg_addr == `VICRB_EVST_OFF) begin
        ev_status_reg <= (ev_status_reg & ~reg_wdata[`VICRB_EV_W-1:0])
          | ev_set;
      end else begin
        ev_status_reg <= ev_status_reg | ev_set;
      end
    end
  end

  assign irq = |(ev_status_reg & ev_mask_reg);

  // read data: memory path or register path, one cycle later
  always @(posedge ref_clk) begin
    if (reset) begin
      rdata_reg <= 32'h0000_0000;
      rvalid_reg <= 1'b0;
      use_mem_reg <= 1'b0;
    end else if (ce) begin
      rvalid_reg <= reg_rd;
      use_mem_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      if (reg_rd) begin
        if (in_svr) begin
          use_mem_reg <= 1'b1;
        end else if (in_prio) begin
          rdata_reg <= {29'h0000_0000,
            prio_reg[word_idx*`VICRB_PRIO_W +: `VICRB_PRIO_W]};
        end else begin
          case (reg_addr)
            `VICRB_NVR_OFF: begin
              if (best_found) begin
                use_mem_reg <= 1'b1;
              end else begin
                rdata_reg <= spurious_vector_reg;
              end
            end
            `VICRB_FVR_OFF: begin
              if (fast_active) begin
                use_mem_reg <= 1'b1;
              end else begin
                rdata_reg <= spurious_vector_reg;
              end
            end
            `VICRB_CSS_OFF: begin
              rdata_reg <= {27'h000_0000, current_source_number_reg};
            end
            `VICRB_PEND_OFF: rdata_reg <= pending_reg;
            `VICRB_ENA_OFF: rdata_reg <= enabled_reg;
            `VICRB_CLS_OFF: begin
              rdata_reg <= {30'h0000_0000, ~core_normal_request_n,
                ~core_fast_request_n};
            end
            `VICRB_SPUR_OFF: rdata_reg <= spurious_vector_reg;
            `VICRB_EVST_OFF: begin
              rdata_reg <= {29'h0000_0000, ev_status_reg};
            end
            `VICRB_EVMSK_OFF: begin
              rdata_reg <= {29'h0000_0000, ev_mask_reg};
            end
            default: rdata_reg <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // zero outside the answer cycle
  assign reg_rdata = !rvalid_reg ? 32'h0000_0000 :
                     use_mem_reg ? mem_q : rdata_reg;

endmodule
`default_nettype wire

/* File: tb/vicrb_props.sv */
// Purpose: port checker for vicrb_top
// Assumes: ce held high
// Notes: bound to the top module below
`default_nettype none
module vicrb_props (
  // clock, reset
  input wire logic ref_clk,
  input wire logic reset,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // sources and lines
  input wire logic [31:0] src_req,
  input wire logic core_normal_request_n,
  input wire logic core_fast_request_n,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] spur_q;
  logic [31:0] vec0_q;
  logic rd_fv;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // shadows of the two vectors a fast read may return
  always @(posedge ref_clk) begin
    if (reset) begin
      spur_q <= 32'h0;
      vec0_q <= 32'h0;
    end else if (reg_wr && reg_addr == 12'h134) spur_q <= reg_wdata;
    else if (reg_wr && reg_addr == 12'h080) vec0_q <= reg_wdata;
  end
  always @(posedge ref_clk) rd_fv <= reg_rd && reg_addr == 12'h104;
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside answer cycle");
  AST_ENCMD_ZERO: assert property ($past(reg_rd && reg_addr == 12'h120)
    |-> reg_rdata == 32'h0) else $error("enable command read not zero");
  AST_CSS_HIGH: assert property ($past(reg_rd && reg_addr == 12'h108)
    |-> reg_rdata[31:5] == 27'h0) else $error("source number upper bits set");
  AST_CLS_LINES: assert property ($past(reg_rd && reg_addr == 12'h114)
    |-> reg_rdata == {30'h0, !$past(core_normal_request_n),
    !$past(core_fast_request_n)}) else $error("core status mismatch");
  AST_NORM_CAUSE: assert property ($fell(core_normal_request_n)
    |-> $past(|src_req[31:1], 3)) else $error("normal line without source");
  AST_RESET_IDLE: assert property ($fell(reset)
    |-> !irq && core_normal_request_n && core_fast_request_n)
    else $error("outputs active out of reset");
  AST_FVR_SPUR: assert property (rd_fv && core_fast_request_n
    |-> reg_rdata == spur_q) else $error("fast read not spurious vector");
  AST_FVR_VEC: assert property (rd_fv && !core_fast_request_n
    && $past(!core_fast_request_n) |-> reg_rdata == vec0_q)
    else $error("fast read not vector zero");
endmodule
bind vicrb_top vicrb_props u_props (.ref_clk, .reset, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .src_req, .core_normal_request_n,
  .core_fast_request_n, .irq);
`default_nettype wire

/* File: tb/vicrb_core_model.sv */
// Purpose: source and core side of vicrb_top
// Assumes: sources are high-level requests
// Notes: lines reported active high
`default_nettype none
module vicrb_core_model (
  // clock
  input wire logic ref_clk,
  // wanted source levels
  input wire logic [31:0] want,
  output logic [31:0] src_req,
  // core lines
  input wire logic core_normal_request_n,
  input wire logic core_fast_request_n,
  output logic [1:0] lines
);
  timeunit 1ns;
  timeprecision 1ns;
  initial src_req = 32'h0;
  always @(posedge ref_clk) src_req <= want;
  assign lines = {~core_normal_request_n, ~core_fast_request_n};
endmodule
`default_nettype wire

/* File: tb/tb_vicrb_top.sv */
// Purpose: self-checking bench for vicrb_top
// Assumes: ce held high
// Notes: reads queue their expectation; a monitor compares
`default_nettype none
module tb_vicrb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_pend = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] want = 32'h0;
  logic [31:0] spur;
  logic [31:0] vec [0:31];
  logic [31:0] exp_q [$];
  wire [31:0] reg_rdata;
  wire [31:0] src_req;
  wire core_normal_request_n;
  wire core_fast_request_n;
  wire irq;
  wire [1:0] lines;
  integer failures = 0;
  integer samples_checked = 0;
  integer seed = 32'hCA53;
  integer i;
  vicrb_top uut (.ref_clk, .reset, .ce(1'b1), .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .src_req, .core_normal_request_n,
    .core_fast_request_n, .irq);
  vicrb_core_model core (.ref_clk, .want, .src_req, .core_normal_request_n,
    .core_fast_request_n, .lines);
  initial forever #50 ref_clk = ~ref_clk;
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, x, g);
    end
  endtask
  // look mid-cycle, where the answer has settled
  always @(negedge ref_clk) begin
    if (rd_pend) begin
      if (exp_q.size() == 0) chk("queue", 32'h1, 32'h0);
      else chk("reg_rdata", exp_q.pop_front(), reg_rdata);
    end
  end
  always @(posedge ref_clk) rd_pend <= reg_rd;
  task wr(input logic [11:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_rd <= 1'b0;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
  endtask
  task idle(input integer n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask
  task end_sim;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    for (i = 0; i < 32; i++) rd(12'(12'h080 + 4 * i), 32'h0);
    for (i = 0; i < 8; i++) rd(12'(12'h100 + 4 * i), 32'h0);
    for (i = 0; i < 32; i++) begin
      vec[i] = $random(seed);
      wr(12'(12'h080 + 4 * i), vec[i]);
    end
    spur = $random(seed);
    wr(12'h134, spur);
    for (i = 0; i < 32; i++) rd(12'(12'h080 + 4 * i), vec[i]);
    wr(12'h110, 32'hFFFFFFFF);
    wr(12'h108, 32'h1F);
    rd(12'h110, 32'h0);
    rd(12'h108, 32'h0);
    rd(12'h104, spur);
    rd(12'h100, spur);
    rd(12'h150, 32'h1);
    wr(12'h154, 32'h7);
    idle(1);
    chk("irq", 32'h1, {31'h0, irq});
    wr(12'h150, 32'h1);
    wr(12'h120, 32'h0000_0221);
    wr(12'h120, 32'h0);
    rd(12'h110, 32'h0000_0221);
    chk("irq", 32'h0, {31'h0, irq});
    wr(12'h014, 32'h3);
    wr(12'h024, 32'h6);
    want <= 32'h8;
    idle(6);
    rd(12'h10C, 32'h8);
    rd(12'h114, 32'h0);
    want <= 32'h0000_0229;
    idle(6);
    chk("lines", 32'h3, {30'h0, lines});
    rd(12'h10C, 32'h0000_0229);
    rd(12'h114, 32'h3);
    rd(12'h100, vec[9]);
    rd(12'h108, 32'h9);
    rd(12'h104, vec[0]);
    want <= 32'h0000_0021;
    idle(6);
    rd(12'h100, vec[5]);
    rd(12'h108, 32'h5);
    want <= 32'h0;
    idle(6);
    rd(12'h100, spur);
    rd(12'h108, 32'h5);
    idle(3);
    end_sim;
  end
endmodule
`default_nettype wire
